// *** pkg/cdsm_consts.svh ***
// Timing and count constants for the column driver sync monitor
`ifndef CDSM_CONSTS_SVH
`define CDSM_CONSTS_SVH

// Line strobes in one half frame
`define CDSM_STROBES_PER_HALF   81
// Frame cycles kept blank after a resync or reset release
`define CDSM_BLANK_FRAMES       4
// Frame pulses per frame
`define CDSM_PULSES_PER_FRAME   2
// Nominal line strobe period in ns (16 oscillator periods at about 190 kHz)
`define CDSM_STROBE_PERIOD_NS   84211
// Clock period in ns
`define CDSM_CLOCK_PERIOD_NS    20
// Clock cycles a slave holds the shared resync line low
`define CDSM_RESYNC_PULL_CYC    16
// Synchronised pin bit positions
`define CDSM_PIN_FRAME          0
`define CDSM_PIN_STROBE         1
`define CDSM_PIN_LVL_A          2
`define CDSM_PIN_LVL_B          3
`define CDSM_PIN_RESYNC         4
`define CDSM_PIN_BLANK          5
`define CDSM_PIN_MASTER         6
`define CDSM_PIN_COUNT          7
// Pin levels assumed in reset: slave, strobe low, active-low pins high
`define CDSM_PIN_IDLE           7'h3d

`endif

// *** pkg/cdsm_pkg.sv ***
// Types for the column driver sync monitor
package cdsm_pkg;

    // Monitor state, Gray coded along idle, pull, hold, blank
    typedef enum logic [1:0] {
        CDSM_IDLE  = 2'h0,
        CDSM_PULL  = 2'h1,
        CDSM_HOLD  = 2'h3,
        CDSM_BLANK = 2'h2
    } cdsm_state_t;

endpackage

// *** hw/cdsm_timing_gen.sv ***
// Local display timing generator: strobe index, half frame, level selects
`timescale 1ns/1ns
`default_nettype none
`include "cdsm_consts.svh"

module cdsm_timing_gen #(
    parameter int STROBES = `CDSM_STROBES_PER_HALF
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       step,
    output logic [6:0]      idx_r,
    output logic [1:0]      half_r,
    output logic            frame_pulse_n_r,
    output logic            lvl_a_r,
    output logic            lvl_b_r
);

    // Refuse strobe counts the 7-bit index cannot hold
    if (STROBES < 2 || STROBES > 128) begin : g_bad_strobes
        $error("cdsm_timing_gen: STROBES out of range");
    end

    localparam logic [6:0] LAST_IDX = 7'(STROBES - 1);

    // Strobe index and half frame count, cleared while resync is low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idx_r  <= 7'h00;
            half_r <= 2'h0;
        end else if (clear) begin
            idx_r  <= 7'h00;
            half_r <= 2'h0;
        end else if (step) begin
            if (idx_r == LAST_IDX) begin
                idx_r  <= 7'h00;
                half_r <= half_r + 2'h1;
            end else begin
                idx_r <= idx_r + 7'h01;
            end
        end
    end

    // Frame pulse low during the first strobe of each half frame
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_pulse_n_r <= 1'b1;
        end else begin
            frame_pulse_n_r <= (idx_r != 7'h00) || clear;
        end
    end

    // Level select pattern over four half frames
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lvl_a_r <= 1'b1;
            lvl_b_r <= 1'b1;
        end else begin
            lvl_a_r <= ~half_r[1];
            lvl_b_r <= ~idx_r[0] ^ (half_r[0] ^ half_r[1]);
        end
    end

    // Index wraps after the last strobe of a half frame
    property p_wrap;
        @(posedge clock) disable iff (!rst_n)
        (step && !clear && idx_r == LAST_IDX) |=> (idx_r == 7'h00) && (half_r == $past(half_r) + 2'h1);
    endproperty
    AST_HALF_WRAP: assert property (p_wrap) else $error("Strobe index did not wrap");

endmodule // cdsm_timing_gen

`default_nettype wire

// *** hw/cdsm_monitor.sv ***
// Column driver sync monitor: level-select compare, shared resync, blanking
// Notes on behaviour
// - Slave compares received level selects with own
// - A slave mismatch outside blanking pulls shared resync line low
// - Resync low resets display timing to start
// - Blank while resync low plus four frames
// - Compare only at frame pulse rising edge
// - One master drives frame, strobe, level selects
// - Resync stops timing, clears index, half frame and divider
// - Master: two frame pulses, 81 strobes per half
`timescale 1ns/1ns
`default_nettype none
`include "cdsm_consts.svh"

module cdsm_monitor #(
    parameter int STROBE_DIV = `CDSM_STROBE_PERIOD_NS / `CDSM_CLOCK_PERIOD_NS,
    parameter int PULL_CYC   = `CDSM_RESYNC_PULL_CYC
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       master_select,
    input  wire logic       display_blank_n,
    input  wire logic       frame_pulse_n_in,
    output logic            frame_pulse_n_out,
    output logic            frame_pulse_n_oe,
    input  wire logic       line_strobe_in,
    output logic            line_strobe_out,
    output logic            line_strobe_oe,
    input  wire logic       row_level_sel_a_in,
    output logic            row_level_sel_a_out,
    output logic            row_level_sel_a_oe,
    input  wire logic       row_level_sel_b_in,
    output logic            row_level_sel_b_out,
    output logic            row_level_sel_b_oe,
    input  wire logic       resync_request_n_in,
    output logic            resync_request_n_out,
    output logic            resync_request_n_oe,
    output logic            blank_out_n_r
);

    // Refuse values the divider and pull counters cannot hold
    if (STROBE_DIV < 4 || STROBE_DIV > 65535 ||
        PULL_CYC < 8 || PULL_CYC > 255) begin : g_bad_params
        $error("cdsm_monitor: parameter out of range");
    end

    localparam int          NP         = `CDSM_PIN_COUNT;
    localparam logic [15:0] DIV_LAST   = 16'(STROBE_DIV - 1);
    localparam logic [15:0] DIV_HALF   = 16'(STROBE_DIV / 2);
    localparam logic [7:0]  PULL_LAST  = 8'(PULL_CYC - 1);
    localparam logic [3:0]  BLANK_HALF = 4'(`CDSM_BLANK_FRAMES * `CDSM_PULSES_PER_FRAME);

    logic [NP-1:0]       s1_r;
    logic [NP-1:0]       s2_r;
    logic [NP-1:0]       s3_r;
    logic [NP-1:0]       pin_r;
    logic [NP-1:0]       pin_prev_r;
    logic [15:0]         div_r;
    logic                strobe_r;
    logic                step;
    logic                resync_low;
    logic                is_master;
    logic                frame_rise;
    logic                loc_frame_prev_r;
    logic                mismatch;
    logic [6:0]          idx;
    logic [1:0]          half;
    logic                loc_frame_n;
    logic                lvl_a;
    logic                lvl_b;
    logic                oe_r;
    logic [7:0]          pull_cnt_r;
    logic [3:0]          blank_cnt_r;
    cdsm_pkg::cdsm_state_t state_r;
    cdsm_pkg::cdsm_state_t state_nxt;

    // Three-stage pin synchronisers; reset to idle levels so that a slave
    // never drives after reset and the first strobe rise is counted
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= `CDSM_PIN_IDLE;
            s2_r <= `CDSM_PIN_IDLE;
            s3_r <= `CDSM_PIN_IDLE;
        end else begin
            s1_r <= {master_select, display_blank_n, resync_request_n_in,
                     row_level_sel_b_in, row_level_sel_a_in, line_strobe_in,
                     frame_pulse_n_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Accept a pin change once the second and third stages agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_r      <= `CDSM_PIN_IDLE;
            pin_prev_r <= `CDSM_PIN_IDLE;
        end else begin
            for (int i = 0; i < NP; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    pin_r[i] <= s3_r[i];
                end
            end
            pin_prev_r <= pin_r;
        end
    end

    assign is_master  = pin_r[`CDSM_PIN_MASTER];
    assign resync_low = !pin_r[`CDSM_PIN_RESYNC];

    // Oscillator divider, stopped while resync is low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_r    <= 16'h0000;
            strobe_r <= 1'b0;
        end else if (resync_low) begin
            div_r    <= 16'h0000;
            strobe_r <= 1'b0;
        end else begin
            div_r    <= (div_r == DIV_LAST) ? 16'h0000 : div_r + 16'h0001;
            strobe_r <= (div_r < DIV_HALF);
        end
    end

    // Master steps on its own divider, slave on the received strobe rise
    assign step = is_master ? (div_r == DIV_LAST)
                            : (pin_r[`CDSM_PIN_STROBE] && !pin_prev_r[`CDSM_PIN_STROBE]);

    cdsm_timing_gen #(
        .STROBES         (`CDSM_STROBES_PER_HALF)
    ) u_gen (
        .clock           (clock),
        .rst_n           (rst_n),
        .clear           (resync_low),
        .step            (step),
        .idx_r           (idx),
        .half_r          (half),
        .frame_pulse_n_r (loc_frame_n),
        .lvl_a_r         (lvl_a),
        .lvl_b_r         (lvl_b)
    );

    // Local frame edge history for master mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loc_frame_prev_r <= 1'b1;
        end else begin
            loc_frame_prev_r <= loc_frame_n;
        end
    end

    // Rising edge of the frame pulse in use
    assign frame_rise = is_master ? (loc_frame_n && !loc_frame_prev_r)
                                  : (pin_r[`CDSM_PIN_FRAME] && !pin_prev_r[`CDSM_PIN_FRAME]);

    // Any difference between received and local level selects
    assign mismatch = (pin_r[`CDSM_PIN_LVL_A] != lvl_a) || (pin_r[`CDSM_PIN_LVL_B] != lvl_b);

    // Next monitor state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            cdsm_pkg::CDSM_IDLE: begin
                if (resync_low) begin
                    state_nxt = cdsm_pkg::CDSM_HOLD;
                end else if (frame_rise && !is_master && mismatch) begin
                    state_nxt = cdsm_pkg::CDSM_PULL;
                end
            end
            cdsm_pkg::CDSM_PULL: begin
                if (pull_cnt_r == PULL_LAST) begin
                    state_nxt = cdsm_pkg::CDSM_HOLD;
                end
            end
            cdsm_pkg::CDSM_HOLD: begin
                if (!resync_low) begin
                    state_nxt = cdsm_pkg::CDSM_BLANK;
                end
            end
            cdsm_pkg::CDSM_BLANK: begin
                if (resync_low) begin
                    state_nxt = cdsm_pkg::CDSM_HOLD;
                end else if (frame_rise && blank_cnt_r == 4'h1) begin
                    state_nxt = cdsm_pkg::CDSM_IDLE;
                end
            end
            default: begin
                state_nxt = cdsm_pkg::CDSM_IDLE;
            end
        endcase
    end

    // State register; after reset the display is held blank too
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= cdsm_pkg::CDSM_BLANK;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Pull width counter and blanking frame counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pull_cnt_r  <= 8'h00;
            blank_cnt_r <= BLANK_HALF;
        end else begin
            pull_cnt_r <= (state_r == cdsm_pkg::CDSM_PULL) ? pull_cnt_r + 8'h01 : 8'h00;
            if (state_r != cdsm_pkg::CDSM_BLANK) begin
                blank_cnt_r <= BLANK_HALF;
            end else if (frame_rise && blank_cnt_r != 4'h0) begin
                blank_cnt_r <= blank_cnt_r - 4'h1;
            end
        end
    end

    // Pin drivers: shared line pulled only while pulling, master pins by mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resync_request_n_out <= 1'b1;
            resync_request_n_oe  <= 1'b0;
            oe_r                 <= 1'b0;
            blank_out_n_r        <= 1'b0;
        end else begin
            resync_request_n_out <= (state_nxt != cdsm_pkg::CDSM_PULL);
            resync_request_n_oe  <= (state_nxt == cdsm_pkg::CDSM_PULL);
            oe_r                 <= is_master;
            blank_out_n_r        <= pin_r[`CDSM_PIN_BLANK] && (state_r == cdsm_pkg::CDSM_IDLE);
        end
    end

    assign frame_pulse_n_out   = loc_frame_n;
    assign frame_pulse_n_oe    = oe_r;
    assign line_strobe_out     = strobe_r;
    assign line_strobe_oe      = oe_r;
    assign row_level_sel_a_out = lvl_a;
    assign row_level_sel_a_oe  = oe_r;
    assign row_level_sel_b_out = lvl_b;
    assign row_level_sel_b_oe  = oe_r;

    // Checks on the monitor's behaviour
    sequence s_pulling;
        resync_request_n_oe && !resync_request_n_out;
    endsequence

    sequence s_blank_held;
        !blank_out_n_r [*4];
    endsequence

    AST_SAMPLE_AT_FRAME: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == cdsm_pkg::CDSM_IDLE && state_nxt == cdsm_pkg::CDSM_PULL) |-> frame_rise)
        else $error("Resync requested outside a frame rise");
    AST_MISMATCH_PULLS: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == cdsm_pkg::CDSM_IDLE && !resync_low && frame_rise && !is_master && mismatch)
        |=> s_pulling)
        else $error("Mismatch did not pull the resync line");
    AST_MASTER_SILENT: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == cdsm_pkg::CDSM_IDLE && is_master) |=> !resync_request_n_oe)
        else $error("Master drove the resync line");
    AST_MATCH_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == cdsm_pkg::CDSM_IDLE && !mismatch) |=> !resync_request_n_oe)
        else $error("Resync requested without a mismatch");
    AST_PULL_WIDTH: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(resync_request_n_oe) |-> s_pulling [*8])
        else $error("Resync pull too short");
    AST_TIMING_CLEARED: assert property (@(posedge clock) disable iff (!rst_n)
        resync_low |=> (idx == 7'h00) && (half == 2'h0) && (div_r == 16'h0000))
        else $error("Timing not cleared during resync");
    AST_BLANK_AFTER_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(resync_low) |-> ##1 s_blank_held)
        else $error("Display unblanked right after resync release");
    AST_BLANK_FRAMES: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == cdsm_pkg::CDSM_BLANK && state_nxt == cdsm_pkg::CDSM_IDLE)
        |-> frame_rise && blank_cnt_r == 4'h1)
        else $error("Blanking ended early");
    AST_MASTER_DRIVES: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(is_master) |=> frame_pulse_n_oe && line_strobe_oe && row_level_sel_a_oe
                             && row_level_sel_b_oe)
        else $error("Master not driving timing pins");

endmodule // cdsm_monitor

`default_nettype wire

// *** bench/cdsm_master_model.sv ***
// Master column driver model: frame pulse, strobe and level selects
`timescale 1ns/1ns
`default_nettype none

module cdsm_master_model #(
    parameter int DIV     = 8,
    parameter int STROBES = 81
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       en,
    input  wire logic       resync_line,
    input  wire logic       peer_pull,
    input  wire logic [1:0] corrupt,
    output logic            frame_pulse_n,
    output logic            line_strobe,
    output logic            level_a,
    output logic            level_b,
    output logic            pull_oe
);
    logic [15:0] div_r;
    logic [6:0]  idx_r;
    logic [1:0]  half_r;

    // Strobe divider and index; held at the start while the shared line is low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_r  <= 16'h0;
            idx_r  <= 7'h0;
            half_r <= 2'h0;
        end else if (!resync_line || !en) begin
            div_r  <= 16'h0;
            idx_r  <= 7'h0;
            half_r <= 2'h0;
        end else if (div_r != 16'(DIV - 1)) begin
            div_r <= div_r + 16'h1;
        end else begin
            div_r <= 16'h0;
            idx_r <= (idx_r == 7'(STROBES - 1)) ? 7'h0 : idx_r + 7'h1;
            if (idx_r == 7'(STROBES - 1)) begin
                half_r <= half_r + 2'h1;
            end
        end
    end

    // Pins; once released they toggle, since nothing holds their level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            frame_pulse_n <= 1'h1;
            line_strobe   <= 1'h0;
            level_a       <= 1'h1;
            level_b       <= 1'h1;
        end else if (!en) begin
            frame_pulse_n <= ~frame_pulse_n;
            line_strobe   <= ~line_strobe;
            level_a       <= ~level_a;
            level_b       <= ~level_b;
        end else begin
            frame_pulse_n <= (idx_r != 7'h0);
            line_strobe   <= resync_line && (div_r < 16'(DIV / 2)); // strobe low while held
            level_a       <= ~half_r[1] ^ corrupt[0];
            level_b       <= ~idx_r[0] ^ half_r[0] ^ half_r[1] ^ corrupt[1];
        end
    end

    // A peer slave pulling the shared line low on command
    assign pull_oe = en & peer_pull;
endmodule // cdsm_master_model

`default_nettype wire

// *** bench/tb.sv ***
// Testbench for the column driver sync monitor
`timescale 1ns/1ns
`default_nettype none

module tb;
    typedef struct packed {
        logic [1:0]  corrupt;
        logic [15:0] peer_cyc;
        logic        pull;
    } cdsm_row_t;
    cdsm_row_t rows [5] = '{'{2'h0, 16'h0, 1'h0}, '{2'h1, 16'h0, 1'h1},
        '{2'h2, 16'h0, 1'h1}, '{2'h3, 16'h0, 1'h1}, '{2'h0, 16'h12c, 1'h0}};
    logic clock = 1'h0;
    logic rst_n, master_select, display_blank_n, m_en, peer_pull, seen, pf, ps;
    logic [1:0] corrupt;
    logic placement_sel_0, placement_sel_1, panel_orientation;
    logic f_out, f_oe, s_out, s_oe, a_out, a_oe, b_out, b_oe, r_out, r_oe, blank_n;
    logic m_frame, m_strobe, m_a, m_b, m_pull, frame_pin, strobe_pin, a_pin, b_pin, line;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int nf, k, n, last, per, since;

    always #10 clock = ~clock;

    // Pin levels: the driving party wins, the shared line has a pull-up
    assign frame_pin  = f_oe ? f_out : m_frame;
    assign strobe_pin = s_oe ? s_out : m_strobe;
    assign a_pin      = a_oe ? a_out ^ corrupt[0] : m_a;
    assign b_pin      = b_oe ? b_out ^ corrupt[1] : m_b;
    assign line       = ~(r_oe | m_pull);

    cdsm_monitor #(.STROBE_DIV(8)) cdsm_monitor_inst (
        .clock(clock), .rst_n(rst_n), .master_select(master_select),
        .display_blank_n(display_blank_n), .frame_pulse_n_in(frame_pin),
        .frame_pulse_n_out(f_out), .frame_pulse_n_oe(f_oe), .line_strobe_in(strobe_pin),
        .line_strobe_out(s_out), .line_strobe_oe(s_oe), .row_level_sel_a_in(a_pin),
        .row_level_sel_a_out(a_out), .row_level_sel_a_oe(a_oe), .row_level_sel_b_in(b_pin),
        .row_level_sel_b_out(b_out), .row_level_sel_b_oe(b_oe), .resync_request_n_in(line),
        .resync_request_n_out(r_out), .resync_request_n_oe(r_oe), .blank_out_n_r(blank_n));

    cdsm_master_model #(.DIV(8), .STROBES(81)) cdsm_master_model_inst (
        .clock(clock), .rst_n(rst_n), .en(m_en), .resync_line(line),
        .peer_pull(peer_pull), .corrupt(corrupt), .frame_pulse_n(m_frame),
        .line_strobe(m_strobe), .level_a(m_a), .level_b(m_b), .pull_oe(m_pull));

    task automatic tick;
        @(posedge clock);
        #2;
    endtask

    task automatic check_val(input logic [15:0] seen_v, input logic [15:0] exp_v);
        samples_checked++;
        if (seen_v !== exp_v) begin
            $display("mismatch at %0t: seen %h expected %h", $time, seen_v, exp_v);
            n_errors++;
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Counts frame rises from line release until the display comes back
    task automatic blank_frames(output int cnt, output logic pulled);
        logic prev;
        cnt = 0;
        pulled = 1'h0;
        for (int i = 0; i < 2000 && line !== 1'h1; i++) tick();
        check_val(16'(blank_n), 16'h0);
        prev = frame_pin;
        for (int i = 0; i < 9000 && blank_n !== 1'h1; i++) begin
            tick();
            pulled = pulled | r_oe;
            if (prev === 1'h0 && frame_pin === 1'h1) cnt++;
            prev = frame_pin;
        end
    endtask

    // Cuts a hang short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            give_verdict();
        end
    end

    // Main sequence
    initial begin
        rst_n = 1'h0;
        master_select = 1'h0;
        display_blank_n = 1'h1;
        m_en = 1'h1;
        peer_pull = 1'h0;
        corrupt = 2'h0;
        placement_sel_0 = 1'h1;
        placement_sel_1 = 1'h0;
        panel_orientation = 1'h0;
        repeat (12) tick();
        check_val(16'({r_oe, r_out, blank_n, f_oe, s_oe, a_oe, b_oe}), 16'h20);
        rst_n = 1'h1;
        blank_frames(nf, seen);
        check_val(16'(nf), 16'h8);
        display_blank_n = 1'h0;
        repeat (6) tick();
        check_val(16'(blank_n), 16'h0);
        display_blank_n = 1'h1;
        repeat (6) tick();
        check_val(16'(blank_n), 16'h1);
        $display("test reset and display off done");
        foreach (rows[r]) begin
            corrupt = rows[r].corrupt;
            for (k = 0; k < int'(rows[r].peer_cyc); k++) begin
                peer_pull = 1'h1;
                tick();
            end
            peer_pull = 1'h0;
            seen = 1'h0;
            since = 0;
            pf = frame_pin;
            for (k = 0; k < 1400 && rows[r].peer_cyc == 16'h0 && !seen; k++) begin
                tick();
                since = (pf === 1'h0 && frame_pin === 1'h1) ? 0 : since + 1;
                pf = frame_pin;
                seen = (r_oe === 1'h1);
            end
            corrupt = 2'h0;
            check_val(16'(seen), 16'(rows[r].pull));
            if (seen) begin
                check_val(16'(since < 8), 16'h1);
                check_val(16'({r_out, line}), 16'h0);
                for (n = 1; n < 100; n++) begin
                    tick();
                    if (r_oe !== 1'h1) break;
                end
                check_val(16'(n), 16'h10);
            end
            if (rows[r].pull || rows[r].peer_cyc != 16'h0) begin
                blank_frames(nf, seen);
                check_val(16'(nf), 16'h8);
                check_val(16'(seen), 16'h0);
            end else check_val(16'(blank_n), 16'h1);
            $display("test row %0d done", r);
        end
        master_select = 1'h1;
        m_en = 1'h0;
        repeat (8) tick();
        check_val(16'({f_oe, s_oe, a_oe, b_oe}), 16'hf);
        // Disturbed level pins must not make the master pull the line
        corrupt = 2'h3;
        pf = f_out;
        for (k = 0; k < 3000 && !(pf === 1'h1 && f_out === 1'h0); k++) begin
            pf = f_out;
            tick();
        end
        n = 0;
        seen = 1'h0;
        last = 0;
        per = 0;
        ps = s_out;
        pf = f_out;
        for (k = 1; k < 3000; k++) begin
            tick();
            seen = seen | r_oe;
            if (ps === 1'h0 && s_out === 1'h1) begin
                n++;
                per = k - last;
                last = k;
            end
            ps = s_out;
            if (pf === 1'h1 && f_out === 1'h0) break;
            pf = f_out;
        end
        check_val(16'(n), 16'h51);
        check_val(16'(per), 16'h8);
        check_val(16'(seen), 16'h0);
        corrupt = 2'h0;
        $display("test master timing done");
        master_select = 1'h0;
        m_en = 1'h1;
        rst_n = 1'h0;
        repeat (3) tick();
        check_val(16'({r_oe, r_out, blank_n, f_oe, s_oe, a_oe, b_oe}), 16'h20);
        rst_n = 1'h1;
        blank_frames(nf, seen);
        check_val(16'(nf), 16'h8);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule // tb

`default_nettype wire
